// file: rtl/reset_seq_pkg.sv
// shared constants and types for the reset and clock sequencer
package reset_seq_pkg;

    // =========================================================
    // reset phases
    typedef enum logic [1:0] {
        PH_POR     = 2'b00,
        PH_PIN_RST = 2'b01,
        PH_STRETCH = 2'b10,
        PH_RUN     = 2'b11
    } phase_e;

    // =========================================================
    // timing
    localparam int REF_CLK_MHZ = 20;
    localparam int STRETCH_CYCLES = 512;
    localparam int STRETCH_W = 10;
    localparam logic [STRETCH_W-1:0] STRETCH_LAST =
        STRETCH_W'(STRETCH_CYCLES - 1);

    // =========================================================
    // divider limits (ratio minus one)
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] LIM_DIV1 = 3'h0;
    localparam logic [DIV_W-1:0] LIM_DIV2 = 3'h1;
    localparam logic [DIV_W-1:0] LIM_DIV8 = 3'h7;
    localparam int NUM_CLKS = 5;
    localparam int CLK_CORE = 0;
    localparam int CLK_PERIPH = 1;
    localparam int CLK_MEMIF = 2;
    localparam int CLK_AUX_B = 3;
    localparam int CLK_AUX_C = 4;

    // =========================================================
    // reset values
    localparam logic [1:0] BOOT_MODE_RST = 2'h0;
    localparam logic ENDIAN_RST = 1'b0;
    localparam logic PLL_BYPASS_RST = 1'b1;

endpackage

// file: rtl/clk_div_if.sv
// carrier between the sequencer and one clock divider
`timescale 1ns/100ps
`default_nettype none
interface clk_div_if;
    logic [reset_seq_pkg::DIV_W-1:0] limit;
    logic tick;
    logic level;

    modport gen (
        input limit,
        output tick,
        output level
    );
    modport user (
        output limit,
        input tick,
        input level
    );
endinterface
`default_nettype wire

// file: rtl/clk_div.sv
// one programmable clock divider giving a tick and a square level
`timescale 1ns/100ps
`default_nettype none
module clk_div (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // divider link
    clk_div_if.gen dv
);
    typedef struct packed {
        logic [reset_seq_pkg::DIV_W-1:0] cnt;
        logic tick;
        logic level;
    } div_s;

    div_s st_reg;
    div_s st_next;

    // =========================================================
    // count
    always_comb begin
        st_next = st_reg;
        // a shrinking limit is caught by >=, so no cycle is stuck
        if (st_reg.cnt >= dv.limit) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 3'h1;
            st_next.tick = 1'b0;
        end
        // level high over the first half of the period
        st_next.level = (dv.limit == reset_seq_pkg::LIM_DIV1) ? 1'b1 :
            ({1'b0, st_next.cnt} < ({1'b0, dv.limit} + 4'h1) >> 1);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign dv.tick = st_reg.tick;
    assign dv.level = st_reg.level;
endmodule
`default_nettype wire

// file: rtl/strap_latch.sv
// boot configuration straps caught on the rising reset pin edge
`timescale 1ns/100ps
`default_nettype none
module strap_latch (
    // reset pin and power-on reset
    input wire logic ext_rst_n,
    input wire logic arst_n,
    // straps
    input wire logic [1:0] boot_mode_strap,
    input wire logic endian_strap,
    // latched values
    output logic [1:0] boot_mode,
    output logic endian_mode
);
    typedef struct packed {
        logic [1:0] boot;
        logic endian;
    } strap_s;

    strap_s st_reg;
    strap_s st_next;

    always_comb begin
        st_next.boot = boot_mode_strap;
        st_next.endian = endian_strap;
    end

    // the pin edge itself is the capture strobe, no clock involved
    always_ff @(posedge ext_rst_n or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.boot <= reset_seq_pkg::BOOT_MODE_RST;
            st_reg.endian <= reset_seq_pkg::ENDIAN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign boot_mode = st_reg.boot;
    assign endian_mode = st_reg.endian;
endmodule
`default_nettype wire

// file: rtl/reset_clock_sequencer.sv
// reset stretch, clock ratio sequencing and pin group control
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - hold internal reset 512 reference cycles
// - all clocks divide by 8 during pin reset
// - all clocks stay divide by 8 while stretching
// - core clock undivided after both resets
// - peripheral clock divide by 2 after reset
// - memory interface clock divide by 2 after reset
// - memory clock pin follows internal clock when select 0
// - third clock output divide by 8 after reset
// - straps latched on reset pin rising edge
// - memory bus and hold ack float in reset
// - bus request undefined while reset applied
// - serial and timer pins float in reset
// - memory clock and second clock float during pin reset
// - third clock output driven low during pin reset
// - clock pins valid within six core periods
// - loop bypassed after reset until software write
module reset_clock_sequencer (
    // reference clock (ref_clk_in) and power-on reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // board reset pin and straps
    input wire logic ext_rst_n,
    input wire logic [1:0] boot_mode_strap,
    input wire logic endian_strap,
    // configuration
    input wire logic ref_clk_select,
    input wire logic memif_clk_src_sel,
    input wire logic memif_ext_clk,
    // loop controller write port
    input wire logic pll_mode_wr,
    input wire logic pll_mode_bypass,
    // internal clock enables and reset
    output logic core_clk,
    output logic periph_clk,
    output logic memif_int_clk,
    output logic internal_rst_n,
    output logic [1:0] phase,
    // latched configuration
    output logic [1:0] boot_mode,
    output logic endian_mode,
    output logic pll_bypass,
    // clock pins
    output logic memif_clk_out,
    output logic memif_clk_out_oe_n,
    output logic aux_clk_out_b,
    output logic aux_clk_out_b_oe_n,
    output logic aux_clk_out_c,
    output logic aux_clk_out_c_oe_n,
    // pin group enables
    output logic ext_mem_if_oe_n,
    output logic hold_ack_out_oe_n,
    output logic bus_request_valid,
    output logic serial_oe_n,
    output logic timer0_out_oe_n,
    output logic timer1_out_oe_n
);

    // =========================================================
    // state
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic mclk_meta;
        logic mclk_sync;
        reset_seq_pkg::phase_e ph;
        logic [reset_seq_pkg::STRETCH_W-1:0] cnt;
        logic int_rst_n;
        logic clk_pins_on;
        logic groups_on;
        logic bypass;
        logic mclk_out;
        logic auxb_out;
        logic auxc_out;
    } seq_s;

    seq_s st_reg;
    seq_s st_next;

    logic [reset_seq_pkg::DIV_W-1:0] lim [reset_seq_pkg::NUM_CLKS];
    logic [reset_seq_pkg::NUM_CLKS-1:0] ticks;
    logic [reset_seq_pkg::NUM_CLKS-1:0] levels;
    logic run_ratios;

    // =========================================================
    // strap capture
    strap_latch u_straps (
        .ext_rst_n(ext_rst_n),
        .arst_n(arst_n),
        .boot_mode_strap(boot_mode_strap),
        .endian_strap(endian_strap),
        .boot_mode(boot_mode),
        .endian_mode(endian_mode)
    );

    // =========================================================
    // divide ratios per phase
    // dividers keep running under the pin reset; only power-on
    // reset stops them, so phase one still sees divide by 8
    assign run_ratios = (st_reg.ph == reset_seq_pkg::PH_RUN);

    always_comb begin
        for (int i = 0; i < reset_seq_pkg::NUM_CLKS; i++) begin
            lim[i] = reset_seq_pkg::LIM_DIV8;
        end
        if (run_ratios) begin
            lim[reset_seq_pkg::CLK_CORE] = reset_seq_pkg::LIM_DIV1;
            lim[reset_seq_pkg::CLK_PERIPH] =
                reset_seq_pkg::LIM_DIV2;
            lim[reset_seq_pkg::CLK_MEMIF] =
                reset_seq_pkg::LIM_DIV2;
            lim[reset_seq_pkg::CLK_AUX_B] = reset_seq_pkg::LIM_DIV2;
            lim[reset_seq_pkg::CLK_AUX_C] =
                reset_seq_pkg::LIM_DIV8;
        end
    end

    genvar g;
    generate
        for (g = 0; g < reset_seq_pkg::NUM_CLKS; g++) begin : g_div
            clk_div_if dif ();
            assign dif.limit = lim[g];
            assign ticks[g] = dif.tick;
            assign levels[g] = dif.level;
            clk_div u_div (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .clk_en(clk_en),
                .dv(dif)
            );
        end
    endgenerate

    // =========================================================
    // sequencing
    always_comb begin
        st_next = st_reg;
        // the first stage feeds only the second
        st_next.rst_meta = ext_rst_n;
        st_next.rst_sync = st_reg.rst_meta;
        st_next.mclk_meta = memif_ext_clk;
        st_next.mclk_sync = st_reg.mclk_meta;

        case (st_reg.ph)
            reset_seq_pkg::PH_POR: begin
                st_next.ph = reset_seq_pkg::PH_PIN_RST;
            end
            reset_seq_pkg::PH_PIN_RST: begin
                st_next.cnt = '0;
                if (st_reg.rst_sync) begin
                    st_next.ph = reset_seq_pkg::PH_STRETCH;
                    st_next.clk_pins_on = 1'b1;
                end
            end
            reset_seq_pkg::PH_STRETCH: begin
                // select low uses the same count; no other figure
                // is defined for that source
                if (st_reg.cnt == reset_seq_pkg::STRETCH_LAST) begin
                    st_next.ph = reset_seq_pkg::PH_RUN;
                    st_next.int_rst_n = 1'b1;
                    st_next.groups_on = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt + 10'h001;
                end
            end
            reset_seq_pkg::PH_RUN: begin
                if (pll_mode_wr) begin
                    st_next.bypass = pll_mode_bypass;
                end
            end
            default: begin
                st_next.ph = reset_seq_pkg::PH_PIN_RST;
            end
        endcase

        // pin going low wins over every phase
        if (!st_reg.rst_sync) begin
            st_next.ph = reset_seq_pkg::PH_PIN_RST;
            st_next.int_rst_n = 1'b0;
            st_next.clk_pins_on = 1'b0;
            st_next.groups_on = 1'b0;
            st_next.bypass = reset_seq_pkg::PLL_BYPASS_RST;
        end

        // registered pin clocks
        st_next.mclk_out = memif_clk_src_sel ? st_reg.mclk_sync :
            levels[reset_seq_pkg::CLK_MEMIF];
        st_next.auxb_out = levels[reset_seq_pkg::CLK_AUX_B];
        st_next.auxc_out = st_next.clk_pins_on &
            levels[reset_seq_pkg::CLK_AUX_C];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.ph <= reset_seq_pkg::PH_POR;
            st_reg.bypass <= reset_seq_pkg::PLL_BYPASS_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs
    // core at divide by 1 is a clock enable that stays high
    assign core_clk = ticks[reset_seq_pkg::CLK_CORE];
    assign periph_clk = ticks[reset_seq_pkg::CLK_PERIPH];
    assign memif_int_clk = ticks[reset_seq_pkg::CLK_MEMIF];
    assign internal_rst_n = st_reg.int_rst_n;
    assign phase = st_reg.ph;
    assign pll_bypass = st_reg.bypass;

    assign memif_clk_out = st_reg.mclk_out;
    assign memif_clk_out_oe_n = ~st_reg.clk_pins_on;
    assign aux_clk_out_b = st_reg.auxb_out;
    assign aux_clk_out_b_oe_n = ~st_reg.clk_pins_on;
    assign aux_clk_out_c = st_reg.auxc_out;
    assign aux_clk_out_c_oe_n = 1'b0;

    assign ext_mem_if_oe_n = ~st_reg.groups_on;
    assign hold_ack_out_oe_n = ~st_reg.groups_on;
    assign bus_request_valid = st_reg.groups_on;
    assign serial_oe_n = ~st_reg.groups_on;
    assign timer0_out_oe_n = ~st_reg.groups_on;
    assign timer1_out_oe_n = ~st_reg.groups_on;

endmodule
`default_nettype wire

// file: bench/reset_seq_checker.sv
// concurrent checks on the reset and clock sequencer ports
`timescale 1ns/100ps
`default_nettype none
module reset_seq_checker (
    // clock, resets and straps
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ext_rst_n,
    input wire logic [1:0] boot_mode_strap,
    input wire logic endian_strap,
    input wire logic memif_clk_src_sel,
    input wire logic pll_mode_wr,
    // sequencer outputs
    input wire logic core_clk,
    input wire logic periph_clk,
    input wire logic memif_int_clk,
    input wire logic internal_rst_n,
    input wire logic [1:0] phase,
    input wire logic [1:0] boot_mode,
    input wire logic endian_mode,
    input wire logic pll_bypass,
    // pins
    input wire logic memif_clk_out,
    input wire logic memif_clk_out_oe_n,
    input wire logic aux_clk_out_b_oe_n,
    input wire logic aux_clk_out_c,
    input wire logic aux_clk_out_c_oe_n,
    input wire logic ext_mem_if_oe_n,
    input wire logic hold_ack_out_oe_n,
    input wire logic bus_request_valid,
    input wire logic serial_oe_n,
    input wire logic timer0_out_oe_n,
    input wire logic timer1_out_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // =======================================
    // stretch length, too long for a repetition
    logic [10:0] str_cnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            str_cnt <= 11'h000;
        end else begin
            str_cnt <= (phase == 2'h2) ? str_cnt + 11'h001 : 11'h000;
        end
    end
    property p_stretch;
        $rose(internal_rst_n) |-> str_cnt == 11'h200 && phase == 2'h3;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("stretch length");
    property p_div8;
        core_clk && phase == 2'h2 |=> (!core_clk || phase == 2'h3) [*7];
    endproperty
    a_div8: assert property (p_div8)
        else $error("core not div 8");
    property p_core_full;
        phase == 2'h3 && $past(phase, 2) == 2'h3 |-> core_clk;
    endproperty
    a_core_full: assert property (p_core_full)
        else $error("core divided");
    property p_half;
        phase == 2'h3 && $past(phase, 3) == 2'h3 |->
            periph_clk != $past(periph_clk) &&
            memif_int_clk != $past(memif_int_clk);
    endproperty
    a_half: assert property (p_half)
        else $error("clock not div 2");
    property p_memif_pin;
        phase == 2'h3 && $past(phase, 3) == 2'h3 && !memif_clk_src_sel &&
            !$past(memif_clk_src_sel) |->
            memif_clk_out != $past(memif_clk_out);
    endproperty
    a_memif_pin: assert property (p_memif_pin)
        else $error("memif pin");
    property p_aux_c;
        $rose(aux_clk_out_c) && phase == 2'h3 |=>
            (!$rose(aux_clk_out_c) || phase != 2'h3) [*7] ##1
            ($rose(aux_clk_out_c) || phase != 2'h3);
    endproperty
    a_aux_c: assert property (p_aux_c)
        else $error("aux c period");
    property p_float;
        !ext_rst_n |-> ##3 ext_mem_if_oe_n && hold_ack_out_oe_n &&
            serial_oe_n && timer0_out_oe_n && timer1_out_oe_n &&
            !bus_request_valid;
    endproperty
    a_float: assert property (p_float)
        else $error("groups driven");
    property p_clk_pins;
        !ext_rst_n |-> ##3 memif_clk_out_oe_n && aux_clk_out_b_oe_n &&
            !aux_clk_out_c && !aux_clk_out_c_oe_n;
    endproperty
    a_clk_pins: assert property (p_clk_pins)
        else $error("clock pins");
    property p_valid;
        $rose(ext_rst_n) |-> ##[1:19] !(memif_clk_out_oe_n ||
            aux_clk_out_b_oe_n || aux_clk_out_c_oe_n);
    endproperty
    a_valid: assert property (p_valid)
        else $error("clock pins late");
    property p_strap;
        $rose(ext_rst_n) |-> boot_mode == boot_mode_strap &&
            endian_mode == endian_strap;
    endproperty
    a_strap: assert property (p_strap)
        else $error("straps");
    property p_bypass;
        phase == 2'h3 && $past(phase) != 2'h3 |-> pll_bypass;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("loop bypass");
    c_done: cover property ($rose(internal_rst_n));
    c_abort: cover property (phase == 2'h2 && !ext_rst_n);
    c_pll: cover property (pll_mode_wr && phase == 2'h3);
endmodule
bind reset_clock_sequencer reset_seq_checker reset_seq_checker_i (.*);
`default_nettype wire

// file: bench/board_model.sv
// board reset source and boot straps
`timescale 1ns/100ps
`default_nettype none
module board_model (
    // clock
    input wire logic sys_clk,
    // pin and straps
    output logic ext_rst_n,
    output logic [1:0] boot_mode_strap,
    output logic endian_strap
);
    initial begin
        ext_rst_n = 1'b0;
        {boot_mode_strap, endian_strap} = 3'h0;
    end
    // straps valid at the fall, well ahead of the rising edge
    task automatic pulse(input int low_cyc, input logic [2:0] cfg);
        {boot_mode_strap, endian_strap} = cfg;
        ext_rst_n = 1'b0;
        repeat (low_cyc) @(posedge sys_clk);
        #2 ext_rst_n = 1'b1;
    endtask
    // hold time over: straps no longer show the latched value
    always @(posedge ext_rst_n) begin
        repeat (8) @(posedge sys_clk);
        #2 {boot_mode_strap, endian_strap} = ~{boot_mode_strap, endian_strap};
    end
endmodule
`default_nettype wire

// file: bench/reset_clock_sequencer_tb_top.sv
// self-checking bench for the reset and clock sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_clock_sequencer_tb_top;
    logic sys_clk = 1'b0;
    logic arst_n, memif_clk_src_sel, pll_mode_wr, pll_mode_bypass;
    logic clk_en = 1'b1;
    logic ref_clk_select = 1'b1;
    logic memif_ext_clk = 1'b0;
    wire logic ext_rst_n, endian_strap;
    wire logic [1:0] boot_mode_strap;
    logic core_clk, periph_clk, memif_int_clk, internal_rst_n;
    logic [1:0] phase, boot_mode;
    logic endian_mode, pll_bypass, memif_clk_out, memif_clk_out_oe_n;
    logic aux_clk_out_b, aux_clk_out_b_oe_n, aux_clk_out_c;
    logic aux_clk_out_c_oe_n, ext_mem_if_oe_n, hold_ack_out_oe_n;
    logic bus_request_valid, serial_oe_n, timer0_out_oe_n, timer1_out_oe_n;
    int mismatches = 0, num_checks = 0, cyc = 0, t0;
    logic [2:0] cfg;
    logic b;
    wire logic [7:0] grp = {memif_clk_out_oe_n, aux_clk_out_b_oe_n,
        ext_mem_if_oe_n, hold_ack_out_oe_n, serial_oe_n, timer0_out_oe_n,
        timer1_out_oe_n, bus_request_valid};
    reset_clock_sequencer reset_clock_sequencer_i (.*);
    board_model board_i (.*);
    always #25 sys_clk = ~sys_clk;
    // external memory clock, high one cycle in four, so that the pin
    // count tells the two sources apart
    always begin
        repeat (3) @(posedge sys_clk);
        #2 memif_ext_clk = 1'b1;
        @(posedge sys_clk);
        #2 memif_ext_clk = 1'b0;
    end
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge sys_clk);
        #2;
    endtask
    // high samples over 32 cycles: 32 / ratio for ticks, 16 for squares
    task automatic win(input int e0, e1, e2, e3, e4);
        int h [6];
        logic [5:0] v;
        h = '{default: 0};
        repeat (32) begin
            tick();
            v = {aux_clk_out_b, aux_clk_out_c, memif_clk_out, memif_int_clk,
                periph_clk, core_clk};
            for (int i = 0; i < 6; i++) h[i] += int'(v[i] === 1'b1);
        end
        chk("aux_b", h[5], 16);
        chk("core", h[0], e0);
        chk("periph", h[1], e1);
        chk("memif", h[2], e2);
        if (e3 >= 0) chk("memif_pin", h[3], e3);
        chk("aux_c", h[4], e4);
    endtask
    initial begin
        arst_n = 1'b0;
        memif_clk_src_sel = 1'b0;
        pll_mode_wr = 1'b0;
        pll_mode_bypass = 1'b0;
        void'($urandom(32'h0536));
        repeat (6) tick();
        arst_n = 1'b1;
        repeat (4) tick();
        chk("phase", phase, 1);
        chk("grp_pin", grp, 8'hFE);
        win(4, 4, 4, -1, 0);
        for (int it = 0; it < 2; it++) begin
            cfg = 3'($urandom);
            memif_clk_src_sel = it[0];
            board_i.pulse(10 + $urandom_range(20), cfg);
            if (it == 1) begin
                // pin pulled again in mid-stretch restarts the count
                repeat (40) tick();
                board_i.pulse(12, cfg);
            end
            t0 = cyc;
            do tick(); while (memif_clk_out_oe_n !== 1'b0);
            chk("pin_dly", cyc - t0, 3);
            chk("grp_str", grp, 8'h3E);
            chk("phase", phase, 2);
            win(4, 4, 4, it ? 8 : 16, 16);
            pll_mode_wr = 1'b1;
            tick();
            pll_mode_wr = 1'b0;
            tick();
            chk("pll_str", pll_bypass, 1);
            do tick(); while (internal_rst_n !== 1'b1);
            chk("stretch", cyc - t0,
                3 + reset_seq_pkg::STRETCH_CYCLES);
            chk("grp_run", grp, 8'h01);
            chk("boot", {boot_mode, endian_mode}, cfg);
            chk("pll_run", pll_bypass, 1);
            tick();
            win(32, 16, 16, it ? 8 : 16,
                16);
            b = 1'($urandom);
            pll_mode_wr = 1'b1;
            pll_mode_bypass = b;
            tick();
            pll_mode_wr = 1'b0;
            tick();
            chk("pll_wr", pll_bypass, b);
        end
        end_sim();
    end
endmodule
`default_nettype wire
